// ---- hw/ptrm_pkg.sv ----
/*
 * ptrm_pkg: constants and types shared by the pci target read / master termination bridge.
 * assumes a single 25 MHz pci clock domain.
 */
`default_nettype none
package ptrm_pkg;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned BAR_N           = 2;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // master abort window, in clocks after frame asserted
  localparam int unsigned DEVSEL_WAIT_CLK = 5;
  localparam logic [7:0]  DEVSEL_WAIT_Q   = 8'h05;
  localparam logic [31:0] BAR0_BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] BAR1_BASE_RST   = 32'h0001_0000;
  localparam logic [31:0] BAR_MASK        = 32'hffff_0000;
  localparam logic [3:0]  CMD_IO_RD       = 4'h2;
  localparam logic [3:0]  CMD_MEM_RD      = 4'h6;
  localparam logic [3:0]  CMD_CFG_RD      = 4'ha;
  localparam logic [3:0]  CMD_CFG_WR      = 4'hb;

  typedef enum logic [2:0] {
    PTRM_END_NORMAL    = 3'h0,
    PTRM_END_TIMEOUT   = 3'h1,
    PTRM_END_NO_TARGET = 3'h2,
    PTRM_END_TGT_ABORT = 3'h3,
    PTRM_END_RETRY     = 3'h4,
    PTRM_END_DISCON    = 3'h5,
    PTRM_END_GNT_ABORT = 3'h6,
    PTRM_END_LOCAL     = 3'h7
  } ptrm_end_t;

  typedef enum logic [3:0] {
    PTRM_LM_IDLE     = 4'h0,
    PTRM_LM_ADDR_LD  = 4'h1,
    PTRM_LM_BUS_TRAN = 4'h2,
    PTRM_LM_BUS_TERM = 4'h3
  } ptrm_lm_state_t;
endpackage : ptrm_pkg
`default_nettype wire

// ---- hw/ptrm_fifo.sv ----
/*
 * ptrm_fifo: parameterised valid/ready fifo on the read data path.
 * assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrm_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ptrm_fifo
`default_nettype wire

// ---- hw/ptrm_core.sv ----
/*
 * ptrm_core: pci master termination reporting and 32-bit target single read.
 * assumes pci pins already resolved into in/out/oe triples outside; one pci clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrm_core
  import ptrm_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // pci target pins
  input  wire logic                    frame_n_in,
  input  wire logic                    irdy_n_in,
  input  wire logic [31:0]             ad_in,
  input  wire logic [3:0]              cbe_n_in,
  output logic      [31:0]             ad_out,
  output logic                         ad_oe_n,
  output logic                         devsel_n_out,
  output logic                         trdy_n_out,
  output logic                         tctl_oe_n,
  input  wire logic                    claim_speed_setting,
  // master side status from the bus engine
  input  wire logic                    mst_frame_n,
  input  wire logic                    mst_gnt_n,
  input  wire logic                    mst_lat_expired,
  input  wire logic                    mst_devsel_n,
  input  wire logic                    mst_trdy_n,
  input  wire logic                    mst_irdy_n,
  input  wire logic                    mst_stop_n,
  input  wire logic                    mst_addr_load,
  input  wire logic                    mst_last,
  input  wire logic                    mst_local_fail,
  input  wire logic                    local_master_abort_req_n,
  output logic                         mst_end_req,
  output ptrm_pkg::ptrm_end_t          master_end_code,
  output ptrm_pkg::ptrm_lm_state_t     local_master_state,
  // local target back end
  output logic      [31:0]             target_addr_to_backend,
  output logic      [3:0]              target_cmd_to_backend,
  output logic      [ptrm_pkg::BAR_N-1:0] bar_hit,
  output logic                         target_access_active_n,
  input  wire logic                    local_target_ready_n,
  output logic                         local_target_xfer_strobe_n,
  input  wire logic [31:0]             l_ad_in,
  output logic                         cfg_access,
  input  wire logic [31:0]             cfg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] frame_s;
  logic [1:0] irdy_s;
  logic [1:0] dsel_s;
  logic [1:0] trdy_s;
  logic [1:0] stop_s;
  logic [1:0] gnt_s;
  logic [1:0] abrt_s;
  logic [1:0] lrdy_s;
  logic [1:0] slow_s;
  logic [31:0] ad_s1;
  logic [31:0] ad_s2;
  logic [3:0]  cbe_s1;
  logic [3:0]  cbe_s2;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_s <= 2'h3;
      irdy_s  <= 2'h3;
      dsel_s  <= 2'h3;
      trdy_s  <= 2'h3;
      stop_s  <= 2'h3;
      gnt_s   <= 2'h3;
      abrt_s  <= 2'h3;
      lrdy_s  <= 2'h3;
      slow_s  <= 2'h0;
      ad_s1   <= '0;
      ad_s2   <= '0;
      cbe_s1  <= 4'hf;
      cbe_s2  <= 4'hf;
    end else begin
      frame_s <= {frame_s[0], frame_n_in};
      irdy_s  <= {irdy_s[0], irdy_n_in};
      dsel_s  <= {dsel_s[0], mst_devsel_n};
      trdy_s  <= {trdy_s[0], mst_trdy_n};
      stop_s  <= {stop_s[0], mst_stop_n};
      gnt_s   <= {gnt_s[0], mst_gnt_n};
      abrt_s  <= {abrt_s[0], local_master_abort_req_n};
      lrdy_s  <= {lrdy_s[0], local_target_ready_n};
      slow_s  <= {slow_s[0], claim_speed_setting};
      ad_s1   <= ad_in;
      ad_s2   <= ad_s1;
      cbe_s1  <= cbe_n_in;
      cbe_s2  <= cbe_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master termination tracking
  logic [7:0]     dsel_cnt_q;
  logic           first_q;
  logic           tran_clk1_q;
  logic           abort_pend_q;
  logic           in_tran;
  logic           phase_done;
  ptrm_end_t      end_d;
  logic           end_now;

  assign in_tran    = (local_master_state == PTRM_LM_BUS_TRAN);
  assign phase_done = !mst_irdy_n && !trdy_s[1];

  always_comb begin
    end_now = 1'b1;
    end_d   = PTRM_END_NORMAL;
    if (!in_tran) begin
      end_now = 1'b0;
    end else if (mst_local_fail) begin
      end_d = PTRM_END_LOCAL;
    end else if (dsel_s[1] && stop_s[1] == 1'b0) begin
      end_d = PTRM_END_TGT_ABORT;
    end else if (dsel_s[1] && dsel_cnt_q >= DEVSEL_WAIT_Q) begin
      end_d = PTRM_END_NO_TARGET;
    end else if (!stop_s[1] && trdy_s[1] && first_q) begin
      end_d = PTRM_END_RETRY;
    end else if (!stop_s[1]) begin
      end_d = PTRM_END_DISCON;
    end else if (abort_pend_q && phase_done) begin
      end_d = PTRM_END_LOCAL;
    end else if (gnt_s[1] && mst_lat_expired) begin
      end_d = PTRM_END_TIMEOUT;
    end else if (gnt_s[1] && phase_done && !mst_last) begin
      end_d = PTRM_END_GNT_ABORT;
    end else if (mst_last && phase_done) begin
      end_d = PTRM_END_NORMAL;
    end else begin
      end_now = 1'b0;
    end
  end

  assign mst_end_req = end_now;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      local_master_state <= PTRM_LM_IDLE;
      first_q            <= 1'b0;
      tran_clk1_q        <= 1'b0;
      dsel_cnt_q         <= '0;
    end else begin
      case (local_master_state)
        PTRM_LM_IDLE: begin
          if (mst_addr_load) begin
            local_master_state <= PTRM_LM_ADDR_LD;
          end
        end
        PTRM_LM_ADDR_LD: begin
          if (!mst_frame_n) begin
            local_master_state <= PTRM_LM_BUS_TRAN;
            first_q            <= 1'b1;
            tran_clk1_q        <= 1'b1;
            dsel_cnt_q         <= '0;
          end
        end
        PTRM_LM_BUS_TRAN: begin
          first_q     <= first_q && trdy_s[1];
          tran_clk1_q <= 1'b0;
          if (dsel_s[1] && dsel_cnt_q != 8'hff) begin
            dsel_cnt_q <= dsel_cnt_q + 8'h01;
          end
          if (end_now) begin
            local_master_state <= PTRM_LM_BUS_TERM;
          end
        end
        PTRM_LM_BUS_TERM: begin
          local_master_state <= PTRM_LM_IDLE;
        end
        default: begin
          local_master_state <= PTRM_LM_IDLE;
        end
      endcase
    end
  end

  // abort requests in address load or the first transaction clock are dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      abort_pend_q <= 1'b0;
    end else if (!in_tran || end_now) begin
      abort_pend_q <= 1'b0;
    end else if (!abrt_s[1] && !tran_clk1_q) begin
      abort_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      master_end_code <= PTRM_END_NORMAL;
    end else if (end_now) begin
      master_end_code <= end_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target single read
  typedef enum logic [2:0] {
    TS_IDLE, TS_DECODE, TS_HIT, TS_DATA, TS_DONE, TS_CFG
  } ptrm_tstate_t;

  function automatic logic [BAR_N-1:0] bar_decode(input logic [31:0] a);
    bar_decode[0] = ((a & BAR_MASK) == BAR0_BASE_RST);
    bar_decode[1] = ((a & BAR_MASK) == BAR1_BASE_RST);
  endfunction : bar_decode

  function automatic logic is_read(input logic [3:0] c);
    is_read = (c == CMD_IO_RD) || (c == CMD_MEM_RD);
  endfunction : is_read

  ptrm_tstate_t ts_q;
  logic         frame_prev_q;
  logic         addr_phase;
  logic [1:0]   rdy_pipe_q;
  logic [31:0]  fifo_out;
  logic         fifo_valid;
  logic         fifo_in_ready;
  logic         fifo_pop;
  logic         push;

  assign addr_phase = frame_prev_q && !frame_s[1];
  assign push       = !local_target_xfer_strobe_n && (ts_q == TS_HIT || ts_q == TS_DATA);
  // the data phase needs the master ready as well
  assign fifo_pop   = (ts_q == TS_DATA) && rdy_pipe_q[1] && fifo_valid && !irdy_s[1];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_prev_q <= 1'b1;
    end else begin
      frame_prev_q <= frame_s[1];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ts_q                   <= TS_IDLE;
      target_addr_to_backend <= '0;
      target_cmd_to_backend  <= '0;
      bar_hit                <= '0;
      target_access_active_n <= 1'b1;
      devsel_n_out           <= 1'b1;
      tctl_oe_n              <= 1'b1;
      cfg_access             <= 1'b0;
    end else begin
      case (ts_q)
        TS_IDLE: begin
          if (addr_phase) begin
            target_addr_to_backend <= ad_s2;
            target_cmd_to_backend  <= ~cbe_s2;
            ts_q                   <= TS_DECODE;
          end
        end
        TS_DECODE: begin
          if (target_cmd_to_backend == CMD_CFG_RD || target_cmd_to_backend == CMD_CFG_WR) begin
            cfg_access   <= 1'b1;
            devsel_n_out <= (target_cmd_to_backend != CMD_CFG_RD);
            tctl_oe_n    <= (target_cmd_to_backend != CMD_CFG_RD);
            ts_q         <= TS_CFG;
          end else if (is_read(target_cmd_to_backend) &&
                       |bar_decode(target_addr_to_backend)) begin
            bar_hit                <= bar_decode(target_addr_to_backend);
            target_access_active_n <= 1'b0;
            // fast timing claims together with the hits
            devsel_n_out           <= slow_s[1];
            tctl_oe_n              <= slow_s[1];
            ts_q                   <= TS_HIT;
          end else begin
            ts_q <= TS_IDLE;
          end
        end
        TS_HIT: begin
          // slow timing claims one clock after the hits
          devsel_n_out <= 1'b0;
          tctl_oe_n    <= 1'b0;
          ts_q         <= TS_DATA;
        end
        TS_DATA: begin
          if (fifo_pop) begin
            ts_q <= TS_DONE;
          end
        end
        TS_DONE: begin
          devsel_n_out           <= 1'b1;
          tctl_oe_n              <= 1'b1;
          bar_hit                <= '0;
          target_access_active_n <= 1'b1;
          ts_q                   <= TS_IDLE;
        end
        TS_CFG: begin
          cfg_access <= 1'b0;
          ts_q       <= TS_DONE;
        end
        default: begin
          ts_q <= TS_IDLE;
        end
      endcase
    end
  end

  // strobe follows sampled ready by one clock; ready then data two clocks on
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      local_target_xfer_strobe_n <= 1'b1;
      rdy_pipe_q                 <= 2'h0;
    end else begin
      // one strobe per read: synced ready stays low a few clocks after the back end drops it
      local_target_xfer_strobe_n <= !(!lrdy_s[1] && !target_access_active_n && !fifo_valid &&
                                      local_target_xfer_strobe_n && fifo_in_ready &&
                                      ts_q != TS_DONE);
      rdy_pipe_q <= {rdy_pipe_q[0], !lrdy_s[1] && !target_access_active_n};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trdy_n_out <= 1'b1;
      ad_out     <= '0;
      ad_oe_n    <= 1'b1;
    end else if (fifo_pop) begin
      trdy_n_out <= 1'b0;
      ad_out     <= fifo_out;
      ad_oe_n    <= 1'b0;
    end else if (ts_q == TS_CFG && target_cmd_to_backend == CMD_CFG_RD) begin
      trdy_n_out <= 1'b0;
      ad_out     <= cfg_rdata;
      ad_oe_n    <= 1'b0;
    end else begin
      trdy_n_out <= 1'b1;
      ad_oe_n    <= 1'b1;
    end
  end

  // back end word taken while strobe is low
  ptrm_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_data   (l_ad_in),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );
endmodule : ptrm_core
`default_nettype wire

// ---- verification/ptrm_checker.sv ----
/*
 * ptrm_checker: concurrent checks on the ports of ptrm_core.
 * assumes a bind into ptrm_core and the single core_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrm_checker
  import ptrm_pkg::*;
(
  input wire logic                     core_clk,
  input wire logic                     nrst,
  input wire logic                     ad_oe_n,
  input wire logic                     devsel_n_out,
  input wire logic                     trdy_n_out,
  input wire logic                     tctl_oe_n,
  input wire logic                     claim_speed_setting,
  input wire logic                     local_target_ready_n,
  input wire logic                     local_target_xfer_strobe_n,
  input wire logic [ptrm_pkg::BAR_N-1:0] bar_hit,
  input wire logic                     target_access_active_n,
  input wire logic                     cfg_access,
  input wire logic                     mst_end_req,
  input wire ptrm_pkg::ptrm_lm_state_t local_master_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  chk_end_in_tran: assert property (mst_end_req |-> local_master_state == PTRM_LM_BUS_TRAN)
    else $error("end request outside transaction state");
  chk_end_to_term: assert property (mst_end_req |=> local_master_state == PTRM_LM_BUS_TERM)
    else $error("end request did not reach termination state");
  chk_hit_access: assert property ($fell(target_access_active_n) |-> bar_hit != '0 && $past(bar_hit) == '0)
    else $error("access indication not paired with hit");
  chk_devsel_slow: assert property (
    $fell(devsel_n_out) && claim_speed_setting && !cfg_access |->
    $past(bar_hit) != '0 && $past(bar_hit, 2) == '0)
    else $error("slow device select not one clock after hit");
  chk_devsel_fast: assert property (
    $fell(devsel_n_out) && !claim_speed_setting && !cfg_access |->
    bar_hit != '0 && $past(bar_hit) == '0)
    else $error("fast device select not with the hit");
  chk_trdy_single: assert property (!trdy_n_out |=> trdy_n_out)
    else $error("target ready held past the data phase");
  chk_trdy_drives: assert property (!trdy_n_out |-> !ad_oe_n && !devsel_n_out && !tctl_oe_n)
    else $error("target ready without driven data and select");
  // the back end holds ready until it sees the strobe, so three clocks back is safe
  chk_strobe_ready: assert property ($fell(local_target_xfer_strobe_n) |-> $past(local_target_ready_n, 3) == 1'b0)
    else $error("strobe without local ready");
  chk_trdy_strobe: assert property ($fell(trdy_n_out) && bar_hit != '0 |-> !$past(local_target_xfer_strobe_n) || !$past(local_target_xfer_strobe_n, 2))
    else $error("target ready without prior strobe");
  chk_done_clears: assert property ($rose(devsel_n_out) |-> ##[0:2] (bar_hit == '0 && target_access_active_n && local_target_xfer_strobe_n))
    else $error("hits or strobe left after completion");
  chk_cfg_quiet: assert property (cfg_access |-> target_access_active_n && local_target_xfer_strobe_n)
    else $error("back end signalled on config access");
endmodule : ptrm_checker
bind ptrm_core ptrm_checker u_chk (.core_clk, .nrst, .ad_oe_n, .devsel_n_out, .trdy_n_out,
  .tctl_oe_n, .claim_speed_setting, .local_target_ready_n, .local_target_xfer_strobe_n,
  .bar_hit, .target_access_active_n, .cfg_access, .mst_end_req, .local_master_state);
`default_nettype wire

// ---- verification/ptrm_backend_model.sv ----
/*
 * ptrm_backend_model: local target back end answering single reads.
 * assumes the bench sets wait_clk and word before each access.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrm_backend_model (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        target_access_active_n,
  input  wire logic        local_target_xfer_strobe_n,
  input  wire logic [7:0]  wait_clk,
  input  wire logic [31:0] word,
  output logic             local_target_ready_n,
  output logic      [31:0] l_ad_in
);
  logic [7:0] cnt_q;
  logic       sent_q;
  ////////////////////////////////////////////////////////////////
  // ready waits wait_clk clocks, then holds until the strobe is seen
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst || target_access_active_n) begin
      cnt_q <= 8'h00;
      sent_q <= 1'b0;
      local_target_ready_n <= 1'b1;
    end else if (!local_target_xfer_strobe_n) begin
      sent_q <= 1'b1;
      local_target_ready_n <= 1'b1;
    end else if (!sent_q && cnt_q >= wait_clk) begin
      local_target_ready_n <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // outside the valid span the lines toggle, so a stale word never passes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      l_ad_in <= 32'h0;
    end else begin
      l_ad_in <= (!local_target_ready_n || !local_target_xfer_strobe_n) ? word : ~l_ad_in;
    end
  end
endmodule : ptrm_backend_model
`default_nettype wire

// ---- verification/pci_target_read_master_termination_bench.sv ----
/*
 * pci_target_read_master_termination_bench: directed bench for ptrm_core.
 * assumes ptrm_backend_model on the local side; the bench plays pci master and master engine.
 */
`timescale 1ns/10ps
`default_nettype none
module pci_target_read_master_termination_bench;
  import ptrm_pkg::*;
  localparam logic [7:0] M_IDLE = 8'h1c;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic frame_n_in, irdy_n_in, claim_speed_setting, mst_frame_n, mst_gnt_n, mst_lat_expired;
  logic mst_devsel_n, mst_trdy_n, mst_irdy_n, mst_stop_n, mst_addr_load, mst_last, cfg_access;
  logic mst_local_fail, local_master_abort_req_n, local_target_ready_n, ad_oe_n, devsel_n_out;
  logic trdy_n_out, tctl_oe_n, mst_end_req, target_access_active_n, local_target_xfer_strobe_n;
  logic [31:0]      ad_in, ad_out, target_addr_to_backend, l_ad_in, cfg_rdata, be_word;
  logic [3:0]       cbe_n_in, target_cmd_to_backend;
  logic [BAR_N-1:0] bar_hit;
  logic [7:0]       be_wait;
  ptrm_end_t        master_end_code;
  ptrm_lm_state_t   local_master_state;
  int num_errors = 0;
  int num_checks = 0;
  // bar0 fast, bar1 slow with back-end waits, address miss, config read
  logic [31:0]      t_addr [4] = '{32'h0000_0010, 32'h0001_0abc, 32'h0002_0000, 32'h0000_0004};
  logic [3:0]       t_cmd [4] = '{CMD_MEM_RD, CMD_IO_RD, CMD_MEM_RD, CMD_CFG_RD};
  logic [7:0]       t_wait [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
  logic [BAR_N-1:0] t_hit [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  // engine inputs per end code: gnt_n lat devsel_n trdy_n irdy_n stop_n last local_fail
  // entry 8 is a local abort request during running data phases
  logic [7:0] m_tab [9] = '{8'h06, 8'hd4, 8'h34, 8'h30, 8'h10, 8'h00, 8'h84, 8'h15, 8'h04};
  always #20 core_clk = ~core_clk;
  ptrm_core uut (.*);
  ptrm_backend_model be (.core_clk, .nrst, .target_access_active_n, .local_target_xfer_strobe_n,
    .wait_clk(be_wait), .word(be_word), .local_target_ready_n, .l_ad_in);
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  task automatic tgt_read(input int i);
    logic [31:0]      got;
    logic [31:0]      exp;
    logic [BAR_N-1:0] hits;
    logic             seen;
    logic             acc;
    seen = 1'b0;
    acc = 1'b0;
    exp = (t_cmd[i] == CMD_CFG_RD) ? cfg_rdata : 32'hc0de_0000 + 32'(i);
    be_word <= 32'hc0de_0000 + 32'(i);
    be_wait <= t_wait[i];
    claim_speed_setting <= (i == 1);
    repeat (3) @(posedge core_clk);
    frame_n_in <= 1'b0;
    ad_in <= t_addr[i];
    cbe_n_in <= ~t_cmd[i];
    @(posedge core_clk);
    frame_n_in <= 1'b1;
    irdy_n_in <= 1'b0;
    ad_in <= ~t_addr[i];
    cbe_n_in <= 4'h0;
    for (int n = 0; n < 40 && !seen; n++) begin
      @(negedge core_clk);
      acc |= (target_access_active_n === 1'b0);
      if (trdy_n_out === 1'b0) begin
        seen = 1'b1;
        got = ad_out;
        hits = bar_hit;
      end
    end
    check(32'(seen), 32'(t_hit[i] != '0 || t_cmd[i] == CMD_CFG_RD));
    check(32'(acc), 32'(t_hit[i] != '0));
    if (seen) begin
      check(got, exp);
      check(32'(hits), 32'(t_hit[i]));
    end
    if (acc) begin
      check(target_addr_to_backend, t_addr[i]);
      check(32'(target_cmd_to_backend), 32'(t_cmd[i]));
    end
    @(posedge core_clk);
    irdy_n_in <= 1'b1;
    if (seen) begin
      @(negedge core_clk);
      check(32'(trdy_n_out), 32'h1);
      @(negedge core_clk);
      check(32'({ad_oe_n, devsel_n_out, local_target_xfer_strobe_n, bar_hit}), 32'h1c);
    end
    repeat (4) @(posedge core_clk);
  endtask : tgt_read
  task automatic mst_case(input int c);
    logic seen;
    seen = 1'b0;
    @(posedge core_clk);
    mst_addr_load <= 1'b1;
    @(posedge core_clk);
    mst_addr_load <= 1'b0;
    mst_frame_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    {mst_gnt_n, mst_lat_expired, mst_devsel_n, mst_trdy_n, mst_irdy_n, mst_stop_n, mst_last,
     mst_local_fail} <= m_tab[c];
    local_master_abort_req_n <= (c != 8);
    for (int n = 0; n < 30 && !seen; n++) begin
      @(negedge core_clk);
      seen = (mst_end_req === 1'b1);
    end
    check(32'(seen), 32'h1);
    @(negedge core_clk);
    check(32'(master_end_code), 32'(c > 7 ? 7 : c));
    check(32'(local_master_state), 32'(PTRM_LM_BUS_TERM));
    @(posedge core_clk);
    mst_frame_n <= 1'b1;
    {mst_gnt_n, mst_lat_expired, mst_devsel_n, mst_trdy_n, mst_irdy_n, mst_stop_n, mst_last,
     mst_local_fail} <= M_IDLE;
    local_master_abort_req_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask : mst_case
  ////////////////////////////////////////////////////////////////
  initial begin
    frame_n_in = 1'b1;
    irdy_n_in = 1'b1;
    claim_speed_setting = 1'b0;
    mst_frame_n = 1'b1;
    mst_addr_load = 1'b0;
    {mst_gnt_n, mst_lat_expired, mst_devsel_n, mst_trdy_n, mst_irdy_n, mst_stop_n, mst_last,
     mst_local_fail} = M_IDLE;
    local_master_abort_req_n = 1'b1;
    ad_in = 32'h0;
    cbe_n_in = 4'hf;
    cfg_rdata = 32'h5a5a_a5a5;
    be_word = 32'h0;
    be_wait = 8'h00;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check(32'({devsel_n_out, trdy_n_out, ad_oe_n, local_target_xfer_strobe_n}), 32'hf);
    check(32'(local_master_state), 32'(PTRM_LM_IDLE));
    for (int i = 0; i < 4; i++) tgt_read(i);
    for (int c = 0; c < 9; c++) mst_case(c);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : pci_target_read_master_termination_bench
`default_nettype wire
